// ==== common/bmd_defines.vh ====
// constants for the banked memory map decoder
// What this block does
// [RULE1] program counter is 13 bits wide
// [RULE2] fetch address wraps onto implemented words
// [RULE3] reset vector 0000h, interrupt vector 0004h
// [RULE4] status bits 6:5 select data bank; only bit 5 is decoded into the data address
// [RULE5] software keeps upper bank bit zero
// [RULE6] each bank spans 128 bytes
// [RULE7] low addresses are registers, upper are ram
// [RULE8] core registers mirrored in both banks
// [RULE9] data reachable direct or through pointer
// [RULE10] separate program and data buses
// [RULE11] eight entry return address stack
// [RULE12] low master clear holds device reset
// [RULE13] clock output at quarter oscillator rate
// [RULE14] pc high loaded from holding latch
// [RULE15] flag writes blocked for flag-setting ops
// [RULE16] direct address is bank bit plus seven bits
`ifndef BMD_DEFINES_VH
`define BMD_DEFINES_VH
`define BMD_OFF_INDIRECT  7'h00
`define BMD_OFF_PCL       7'h02
`define BMD_OFF_STATUS    7'h03
`define BMD_OFF_POINTER   7'h04
`define BMD_OFF_PC_HIGH_LATCH    7'h0a
`define BMD_GPR_BASE      7'h20
`define BMD_RESET_VEC     13'h0000
`define BMD_IRQ_VEC       13'h0004
`define BMD_STATUS_RST    8'h18
`define BMD_BANK_LO_BIT   5
`define BMD_BANK_HI_BIT   6
`define BMD_FLAG_MASK     8'h07
`define BMD_STATUS_WMASK  8'he0
`define BMD_WB_STATUS     8'h00
`define BMD_WB_POINTER    8'h04
`define BMD_WB_PC_HIGH_LATCH     8'h08
`define BMD_WB_PC         8'h0c
`define BMD_WB_SP         8'h10
`define BMD_WB_CTRL       8'h14
`endif

// ==== design/bmd_sync.v ====
// two flip-flop synchroniser for a pin level
`timescale 1ns/1ps
module bmd_sync (
  input  wire clk_i,
  input  wire rst_i,
  input  wire d_i,
  output reg  q_o
);
  reg meta;
  always @(posedge clk_i) begin
    // reset to the idle high level, so no false clear follows reset
    if (rst_i) begin
      meta <= 1'b1;
      q_o  <= 1'b1;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end
endmodule

// ==== design/bmd_stack.v ====
// eight entry circular return address stack
`timescale 1ns/1ps
module bmd_stack #(
  parameter DEPTH = 8,
  parameter AW    = 13
) (
  input  wire          clk_i,
  input  wire          rst_i,
  input  wire          push_i,
  input  wire          pop_i,
  input  wire [AW-1:0] data_i,
  output wire [AW-1:0] top_o,
  output reg  [2:0]    sp_o
);
  reg [AW-1:0] mem [0:DEPTH-1];
  integer i;
  // overflow silently wraps, as real hardware does
  assign top_o = mem[sp_o - 3'h1];
  always @(posedge clk_i) begin
    if (rst_i) begin
      sp_o <= 3'h0;
      for (i = 0; i < DEPTH; i = i + 1)
        mem[i] <= {AW{1'b0}};
    end else if (push_i) begin
      mem[sp_o] <= data_i; // [RULE11]
      sp_o      <= sp_o + 3'h1;
    end else if (pop_i) begin
      sp_o <= sp_o - 3'h1;
    end
  end
endmodule

// ==== design/bmd_core.v ====
// banked memory map decoder with wishbone control port
`timescale 1ns/1ps
`include "bmd_defines.vh"
module bmd_core #(
  parameter PROG_WORDS = 2048,
  parameter PROG_AW    = 11
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        master_clear_n_i,
  input  wire        rc_mode_i,
  // wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [7:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // core side: instruction sequencing
  input  wire        step_i,
  input  wire        irq_i,
  input  wire        call_i,
  input  wire        ret_i,
  input  wire        goto_i,
  input  wire [10:0] goto_addr_i,
  // core side: data access
  input  wire        dacc_i,
  input  wire        dwe_i,
  input  wire        dind_i,
  input  wire [6:0]  dfile_i,
  input  wire [7:0]  dwdata_i,
  input  wire        flag_op_i,
  input  wire [2:0]  flags_i,
  output reg  [7:0]  drdata_o,
  // program and data buses, cycle clock and reset status
  output reg  [12:0] fetch_addr_o,
  output reg  [PROG_AW-1:0] prog_addr_o,
  output reg  [7:0]  data_addr_o,
  output reg         gpr_sel_o,
  output reg         cycle_clock_out_o,
  output reg         in_reset_o
);
  reg [12:0] pc;
  reg [7:0]  status;
  reg [7:0]  indirect_pointer;
  reg [4:0]  pc_high_latch;
  reg [7:0]  gpr [0:255];
  reg [1:0]  div;
  wire       master_clear_n_s;
  wire [12:0] stk_top;
  wire [2:0]  sp;
  reg  [7:0]  eff;
  reg  [12:0] next_pc;
  reg  [7:0]  rd;
  wire in_rst = rst_i | ~master_clear_n_s;
  integer k;

  function [PROG_AW-1:0] wrap;
    input [12:0] a;
    wrap = a[PROG_AW-1:0]; // [RULE2]
  endfunction

  function is_sfr;
    input [6:0] off;
    is_sfr = off < `BMD_GPR_BASE; // [RULE7]
  endfunction

  bmd_sync u_master_clear_n (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (master_clear_n_i),
    .q_o   (master_clear_n_s)
  );

  wire do_push = step_i & (call_i | irq_i) & ~in_rst;
  wire do_pop  = step_i & ret_i & ~irq_i & ~in_rst;
  bmd_stack #(.DEPTH(8), .AW(13)) u_stack (
    .clk_i  (clk_i),
    .rst_i  (in_rst),
    .push_i (do_push),
    .pop_i  (do_pop),
    .data_i (pc + 13'h1),
    .top_o  (stk_top),
    .sp_o   (sp)
  );

  // effective data address
  always @* begin
    if (dind_i || dfile_i == `BMD_OFF_INDIRECT)
      eff = indirect_pointer; // [RULE9]
    else
      eff = {status[`BMD_BANK_LO_BIT], dfile_i}; // [RULE16] [RULE4] [RULE6]
  end

  // register read mux; core registers mirror across banks
  always @* begin
    rd = gpr[eff];
    if (is_sfr(eff[6:0])) begin
      case (eff[6:0]) // [RULE8]
        `BMD_OFF_INDIRECT: rd = 8'h00;
        `BMD_OFF_PCL:      rd = pc[7:0];
        `BMD_OFF_STATUS:   rd = status;
        `BMD_OFF_POINTER:  rd = indirect_pointer;
        `BMD_OFF_PC_HIGH_LATCH:   rd = {3'h0, pc_high_latch};
        default:           rd = 8'h00;
      endcase
    end
  end

  wire dwr = dacc_i & dwe_i & ~in_rst;
  wire wr_pcl = dwr & (eff[6:0] == `BMD_OFF_PCL);
  // bus writes land on the edge at which the master samples ack
  wire wb_wr  = cyc_i & stb_i & we_i & ack_o & sel_i[0];

  always @* begin
    next_pc = pc + 13'h1;
    if (irq_i)
      next_pc = `BMD_IRQ_VEC; // [RULE3]
    else if (ret_i)
      next_pc = stk_top;
    else if (call_i || goto_i)
      next_pc = {pc_high_latch[4:3], goto_addr_i}; // [RULE14]
  end

  always @(posedge clk_i) begin
    if (in_rst) begin
      pc               <= `BMD_RESET_VEC; // [RULE3] [RULE12]
      status           <= `BMD_STATUS_RST;
      indirect_pointer <= 8'h00;
      pc_high_latch    <= 5'h00;
      fetch_addr_o     <= 13'h0000;
      prog_addr_o      <= {PROG_AW{1'b0}};
      data_addr_o      <= 8'h00;
      gpr_sel_o        <= 1'b0;
      drdata_o         <= 8'h00;
      for (k = 0; k < 256; k = k + 1)
        gpr[k] <= 8'h00;
    end else begin
      // separate buses update in the same cycle
      fetch_addr_o <= pc; // [RULE1] [RULE10]
      prog_addr_o  <= wrap(pc); // [RULE2]
      data_addr_o  <= eff; // [RULE10]
      gpr_sel_o    <= dacc_i & ~is_sfr(eff[6:0]);
      if (dacc_i)
        drdata_o <= rd;
      if (wr_pcl)
        pc <= {pc_high_latch, dwdata_i}; // [RULE14]
      else if (step_i)
        pc <= next_pc; // [RULE1]
      if (dwr && !is_sfr(eff[6:0]))
        gpr[eff] <= dwdata_i; // [RULE7]
      if (dwr && eff[6:0] == `BMD_OFF_POINTER)
        indirect_pointer <= dwdata_i;
      if (dwr && eff[6:0] == `BMD_OFF_PC_HIGH_LATCH)
        pc_high_latch <= dwdata_i[4:0];
      if (dwr && eff[6:0] == `BMD_OFF_STATUS) begin
        status[7:5] <= dwdata_i[7:5];
        // flag-setting ops keep their own flags
        if (!flag_op_i)
          status[2:0] <= dwdata_i[2:0]; // [RULE15]
        else
          status[2:0] <= flags_i; // [RULE15]
      end else if (flag_op_i && dacc_i) begin
        status[2:0] <= flags_i;
      end else if (wb_wr && adr_i == `BMD_WB_STATUS) begin
        status <= (status & ~`BMD_STATUS_WMASK) |
                  (dat_i[7:0] & `BMD_STATUS_WMASK); // [RULE4]
      end
      if (wb_wr) begin
        if (adr_i == `BMD_WB_POINTER)
          indirect_pointer <= dat_i[7:0];
        if (adr_i == `BMD_WB_PC_HIGH_LATCH)
          pc_high_latch <= dat_i[4:0];
      end
    end
  end

  // quarter rate cycle clock, only driven in rc mode
  always @(posedge clk_i) begin
    if (rst_i) begin
      div               <= 2'h0;
      cycle_clock_out_o <= 1'b0;
      in_reset_o        <= 1'b1;
    end else begin
      div               <= div + 2'h1;
      cycle_clock_out_o <= rc_mode_i & div[1]; // [RULE13]
      in_reset_o        <= ~master_clear_n_s; // [RULE12]
    end
  end

  // wishbone slave: one wait state, ack for one cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
      case (adr_i)
        `BMD_WB_STATUS:  dat_o <= {24'h0, status};
        `BMD_WB_POINTER: dat_o <= {24'h0, indirect_pointer};
        `BMD_WB_PC_HIGH_LATCH:  dat_o <= {27'h0, pc_high_latch};
        `BMD_WB_PC:      dat_o <= {19'h0, pc};
        `BMD_WB_SP:      dat_o <= {29'h0, sp};
        `BMD_WB_CTRL:    dat_o <= {30'h0, ~master_clear_n_s, rc_mode_i};
        default:         dat_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule

// ==== dv/bmd_chk.sv ====
// port checker for the memory map decoder
`timescale 1ns/1ps
module bmd_chk (
  input wire        clk_i,
  input wire        rst_i,
  input wire        master_clear_n_i,
  input wire        rc_mode_i,
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [7:0]  adr_i,
  input wire        dacc_i,
  input wire        dind_i,
  input wire [6:0]  dfile_i,
  input wire [31:0] dat_o,
  input wire        ack_o,
  input wire [7:0]  data_addr_o,
  input wire        gpr_sel_o,
  input wire [12:0] fetch_addr_o,
  input wire        cycle_clock_out_o,
  input wire        in_reset_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence ack_once; ack_o ##1 !ack_o; endsequence
  sequence hi_lo; cycle_clock_out_o ##1 !cycle_clock_out_o; endsequence
  sequence lo_hi; !cycle_clock_out_o ##1 cycle_clock_out_o; endsequence
  ack_single_a: assert property (
    cyc_i && stb_i && !ack_o |=> ack_once) else $error("bad ack");
  unmapped_zero_a: assert property (
    ack_o && !$past(we_i) && $past(adr_i) >= 8'h18 |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  reset_vector_a: assert property (
    $fell(rst_i) |-> fetch_addr_o == 13'h0000) else $error("bad vector");
  direct_addr_a: assert property (
    $past(dacc_i) && !$past(dind_i) && $past(dfile_i) != 7'h00 |->
    data_addr_o[6:0] == $past(dfile_i))
    else $error("bad direct address");
  gpr_decode_a: assert property (
    $past(dacc_i) |-> gpr_sel_o == (data_addr_o[6:0] >= 7'h20))
    else $error("bad ram select");
  cyc_high_a: assert property (
    $rose(cycle_clock_out_o) && rc_mode_i ##1 rc_mode_i |-> hi_lo)
    else $error("bad high phase");
  cyc_low_a: assert property (
    $fell(cycle_clock_out_o) && rc_mode_i ##1 rc_mode_i |-> lo_hi)
    else $error("bad low phase");
  master_clear_n_hold_a: assert property (
    !master_clear_n_i [*4] |=> in_reset_o) else $error("reset not held");
  master_clear_n_free_a: assert property (
    (master_clear_n_i && !rst_i) [*4] |=> !in_reset_o)
    else $error("stuck in reset");
endmodule
bind bmd_core bmd_chk u_chk (.*);

// ==== dv/banked_memory_map_decoder_test.sv ====
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module banked_memory_map_decoder_test;
  logic clk_i = 0, rst_i = 1, master_clear_n_i = 1, rc_mode_i = 1;
  logic cyc_i = 0, stb_i = 0, we_i = 0, step_i = 0, irq_i = 0;
  logic call_i = 0, ret_i = 0, goto_i = 0, dacc_i = 0, dwe_i = 0;
  logic dind_i = 0, flag_op_i = 0;
  logic [7:0]  adr_i = 0, dwdata_i = 0, v;
  logic [3:0]  sel_i = 0;
  logic [31:0] dat_i = 0, rd;
  logic [10:0] goto_addr_i = 0;
  logic [6:0]  dfile_i = 0, f;
  logic [2:0]  flags_i = 0;
  wire  [31:0] dat_o;
  wire         ack_o, gpr_sel_o, cycle_clock_out_o, in_reset_o;
  wire  [7:0]  drdata_o, data_addr_o;
  wire  [12:0] fetch_addr_o;
  wire  [9:0]  prog_addr_o;
  int          fail_count = 0, check_count = 0, i, k;
  // small variant so the wrap is visible on prog_addr_o
  bmd_core #(.PROG_WORDS(1024), .PROG_AW(10)) dut (.*);
  always #2.5 clk_i = ~clk_i;
  task stop_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wb(input logic w, input logic [7:0] ad, input logic [31:0] dd);
    @(posedge clk_i);
    {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, ad, dd, 4'h1};
    // only the watchdog ends a wait for ack
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    {cyc_i, stb_i} <= 2'b00;
  endtask
  task da(input logic w, input logic ind, input logic [6:0] fa,
          input logic [7:0] dv);
    @(posedge clk_i);
    {dacc_i, dwe_i, dind_i, dfile_i, dwdata_i} <= {1'b1, w, ind, fa, dv};
    @(posedge clk_i);
    dacc_i <= 0;
    #1;
  endtask
  // op is {irq, call, ret, goto}
  task pulse(input logic [3:0] op);
    @(posedge clk_i);
    {step_i, irq_i, call_i, ret_i, goto_i} <= {1'b1, op};
    @(posedge clk_i);
    {step_i, irq_i, call_i, ret_i, goto_i} <= 5'h00;
  endtask
  initial begin
    i = $urandom(15663);
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    #1 chk(fetch_addr_o, 0);
    wb(0, 8'h00, 0); chk(rd, 32'h18);
    wb(0, 8'h20, 0); chk(rd, 0);
    wb(0, 8'h14, 0); chk(rd, 32'h1);
    $display("reset test done");
    // same file in both banks must stay apart; upper bank bit kept zero
    for (i = 0; i < 12; i++) begin
      f = 7'h20 + $urandom % 96;
      v = $urandom;
      for (k = 0; k < 4; k++) begin
        wb(1, 8'h00, {k[0], 5'h0});
        da(k < 2, 0, f, v ^ {8{k[0]}});
        chk(data_addr_o, {k[0], f});
        chk(gpr_sel_o, 1);
        if (k > 1) chk(drdata_o, v ^ {8{k[0]}});
      end
    end
    da(0, 0, 7'h03, 0); chk(gpr_sel_o, 0);
    chk(drdata_o, 8'h38);
    da(1, 0, 7'h0a, 8'h15);
    wb(1, 8'h00, 0); da(0, 0, 7'h0a, 0); chk(drdata_o, 8'h15);
    wb(0, 8'h08, 0); chk(rd, 32'h15);
    wb(1, 8'h04, 32'hc5); da(1, 1, 0, 8'h5a); chk(data_addr_o, 8'hc5);
    wb(1, 8'h00, 32'h20); da(0, 0, 7'h45, 0); chk(drdata_o, 8'h5a);
    da(0, 0, 7'h00, 0); chk(data_addr_o, 8'hc5);
    chk(drdata_o, 8'h5a);
    $display("bank test done");
    wb(1, 8'h08, 32'h1f); da(1, 0, 7'h02, 8'h34);
    repeat (3) @(posedge clk_i);
    wb(0, 8'h0c, 0); chk(rd, 32'h1f34);
    chk(prog_addr_o, 10'h334);
    pulse(4'h8);
    repeat (2) @(posedge clk_i);
    wb(0, 8'h0c, 0); chk(rd, 4);
    wb(0, 8'h10, 0); chk(rd, 1);
    for (i = 0; i < 8; i++) pulse(4'h4);
    wb(0, 8'h10, 0); chk(rd, 1);
    // ninth entry overwrote the oldest, so return lands just past the last call site
    pulse(4'h2);
    wb(0, 8'h0c, 0); chk(rd, 32'h1801);
    wb(0, 8'h10, 0); chk(rd, 0);
    wb(1, 8'h08, 32'h0b);
    goto_addr_i <= 11'($urandom);
    pulse(4'h1);
    wb(0, 8'h0c, 0); chk(rd, {2'b01, goto_addr_i});
    chk(fetch_addr_o, {2'b01, goto_addr_i});
    chk(prog_addr_o, goto_addr_i[9:0]);
    flags_i <= 3'h5;
    flag_op_i <= 1;
    da(1, 0, 7'h03, 8'h02);
    flag_op_i <= 0;
    wb(0, 8'h00, 0); chk(rd[2:0], 3'h5);
    $display("program test done");
    rc_mode_i <= 0;
    wb(0, 8'h14, 0); chk(rd, 0);
    k = 0;
    repeat (8) begin @(posedge clk_i); k += cycle_clock_out_o; end
    chk(k, 0);
    rc_mode_i <= 1;
    repeat (2) @(posedge clk_i);
    k = 0;
    repeat (8) begin @(posedge clk_i); k += cycle_clock_out_o; end
    chk(k, 4);
    $display("clock test done");
    master_clear_n_i <= 0;
    repeat (6) @(posedge clk_i);
    #1 chk(in_reset_o, 1);
    wb(0, 8'h14, 0); chk(rd, 32'h3);
    master_clear_n_i <= 1;
    repeat (4) @(posedge clk_i);
    wb(0, 8'h00, 0); chk(rd, 32'h18);
    wb(0, 8'h0c, 0); chk(rd, 0);
    $display("clear test done");
    stop_test;
  end
  // about 390 cycles expected; generous margin before giving up
  initial begin
    #40000;
    fail_count++;
    stop_test;
  end
endmodule
